/* hw/asq_arbiter.sv */
// Purpose: picks the pending sequencer whose priority encoding ranks highest
// Assumes: encoding 0 ranks highest
// Notes:   equal encodings resolve to the lowest index, so the outcome is at least stable
module asq_arbiter #(
  parameter int NSEQ  = 4,
  parameter int PRI_W = 2
) (
  input  wire logic [NSEQ-1:0]       pend_i,
  input  wire logic [NSEQ*PRI_W-1:0] pri_i,
  output logic      [NSEQ-1:0]       grant_o,
  output logic                       valid_o
);
  logic found;

  always_comb begin
    found   = 1'b0;
    grant_o = '0;
    for (int l = 0; l < (1 << PRI_W); l++) begin
      for (int s = 0; s < NSEQ; s++) begin
        if (!found && pend_i[s] && pri_i[s*PRI_W +: PRI_W] == PRI_W'(l)) begin
          grant_o[s] = 1'b1;
          found      = 1'b1;
        end
      end
    end
    valid_o = found;
  end
endmodule

/* hw/asq_top.sv */
// Purpose: sequencer priority map and software initiate logic behind an AXI4-Lite slave
// Assumes: SEQ_DONE_I comes from converter logic on the same clock
// Notes:   one sequence runs at a time; pending triggers wait in priority order
//
// Functional notes
// - after reset sequencer n holds priority encoding n, so zero ranks highest.
// - each priority is a 2-bit value where 0 ranks highest and 3 lowest.
// - priority fields sit at bits 13:12, 9:8, 5:4 and 1:0 for sequencers 3..0, all read/write.
// - bits 31:14 and the gaps between priority fields are reserved and read-only.
// - a one written to initiate bit n triggers sequencer n only if it is active and its trigger select is 0000 (software).
// - any mix of sequencers may be initiated at once and they run in priority order.
// - the initiate register is write-only, bits 31:4 reserved, reads carry nothing.
// - the priority map decodes at 0x020 and the initiate register at 0x028.
// - each sequencer has a 4-bit trigger select, where 0000 (default) means software.
module asq_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        SEQ_DONE_I,
  output logic [3:0]       SEQ_TRIG_O,
  output logic [3:0]       SEQ_START_O,
  output logic [3:0]       SEQ_RUN_O,
  output logic [3:0]       ACTIVE_SEQ_O
);
  localparam int NSEQ  = asq_pkg::NSEQ;
  localparam int PRI_W = asq_pkg::PRI_W;
  localparam int SEL_W = asq_pkg::SEL_W;
  localparam int STEP  = asq_pkg::FIELD_STEP;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic              awready_ff;
  logic              wready_ff;
  logic              aw_full_ff;
  logic              w_full_ff;
  logic [11:0]       awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              wr_do;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       nxt_rdata;

  // block registers and control
  logic [NSEQ*PRI_W-1:0] pri_ff;
  logic [NSEQ*SEL_W-1:0] sel_ff;
  logic [NSEQ-1:0]       act_ff;
  logic [NSEQ-1:0]       trig_ff;
  logic [NSEQ-1:0]       nxt_trig;
  logic [NSEQ-1:0]       pend_ff;
  logic [NSEQ-1:0]       start_ff;
  logic [NSEQ-1:0]       run_ff;
  logic [NSEQ-1:0]       grant;
  logic                  grant_valid;
  asq_pkg::asq_state_t   state_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // write address and data are taken in either order; the write runs once both are held
  assign wr_do = aw_full_ff && w_full_ff && !bvalid_ff;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      awready_ff <= 1'b0;
      aw_full_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (S_AXI_AWVALID_I && awready_ff) begin
      awready_ff <= 1'b0;
      aw_full_ff <= 1'b1;
      awaddr_ff  <= S_AXI_AWADDR_I;
    end else if (wr_do) begin
      aw_full_ff <= 1'b0;
    end else if (!aw_full_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      wready_ff <= 1'b0;
      w_full_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (S_AXI_WVALID_I && wready_ff) begin
      wready_ff <= 1'b0;
      w_full_ff <= 1'b1;
      wdata_ff  <= S_AXI_WDATA_I;
      wstrb_ff  <= S_AXI_WSTRB_I;
    end else if (wr_do) begin
      w_full_ff <= 1'b0;
    end else if (!w_full_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // decode: unmapped addresses answer SLVERR and change nothing
  always_comb begin
    unique case (awaddr_ff)
      asq_pkg::OFF_ACTIVE, asq_pkg::OFF_TRIG_SEL, asq_pkg::OFF_PRI_MAP,
      asq_pkg::OFF_INITIATE, asq_pkg::OFF_STATUS: wr_hit = 1'b1;
      default:                                    wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= asq_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? asq_pkg::RESP_OKAY : asq_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes honour byte strobes; fields never straddle a byte
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pri_ff <= '0;
      for (int n = 0; n < NSEQ; n++) begin
        pri_ff[n*PRI_W +: PRI_W] <= asq_pkg::PRI_RESET[n*STEP +: PRI_W];
      end
    end else if (wr_do && awaddr_ff == asq_pkg::OFF_PRI_MAP) begin
      for (int n = 0; n < NSEQ; n++) begin
        if (wstrb_ff[(n*STEP)/asq_pkg::BYTE_W]) begin
          pri_ff[n*PRI_W +: PRI_W] <= wdata_ff[n*STEP +: PRI_W];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      sel_ff <= asq_pkg::SEL_RESET;
    end else if (wr_do && awaddr_ff == asq_pkg::OFF_TRIG_SEL) begin
      for (int n = 0; n < NSEQ; n++) begin
        if (wstrb_ff[(n*STEP)/asq_pkg::BYTE_W]) begin
          sel_ff[n*SEL_W +: SEL_W] <= wdata_ff[n*STEP +: SEL_W];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      act_ff <= asq_pkg::ACTIVE_RESET;
    end else if (wr_do && awaddr_ff == asq_pkg::OFF_ACTIVE && wstrb_ff[0]) begin
      act_ff <= wdata_ff[NSEQ-1:0];
    end
  end

  // initiate: nothing is stored, a one becomes a single trigger pulse
  always_comb begin
    nxt_trig = '0;
    if (wr_do && awaddr_ff == asq_pkg::OFF_INITIATE && wstrb_ff[0]) begin
      for (int n = 0; n < NSEQ; n++) begin
        nxt_trig[n] = wdata_ff[n] && act_ff[n]
                      && sel_ff[n*SEL_W +: SEL_W] == asq_pkg::SEL_SOFTWARE;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      trig_ff <= '0;
    end else begin
      trig_ff <= nxt_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // execution order: pending triggers are started one at a time by priority
  asq_arbiter #(
    .NSEQ  (NSEQ),
    .PRI_W (PRI_W)
  ) i_asq_arbiter (
    .pend_i  (pend_ff),
    .pri_i   (pri_ff),
    .grant_o (grant),
    .valid_o (grant_valid)
  );

  // a new trigger in the cycle its bit is cleared survives; deactivation drops it
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pend_ff <= '0;
    end else if (state_ff == asq_pkg::ST_IDLE && grant_valid) begin
      pend_ff <= ((pend_ff & ~grant) | trig_ff) & act_ff;
    end else begin
      pend_ff <= (pend_ff | trig_ff) & act_ff;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_ff <= asq_pkg::ST_IDLE;
      start_ff <= '0;
      run_ff   <= '0;
    end else begin
      start_ff <= '0;
      unique case (state_ff)
        asq_pkg::ST_IDLE: begin
          if (grant_valid) begin
            start_ff <= grant;
            run_ff   <= grant;
            state_ff <= asq_pkg::ST_RUN;
          end
        end
        asq_pkg::ST_RUN: begin
          if (SEQ_DONE_I) begin
            run_ff   <= '0;
            state_ff <= asq_pkg::ST_IDLE;
          end
        end
        default: begin
          run_ff   <= '0;
          state_ff <= asq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel; reserved bits and the write-only initiate register read as zero
  always_comb begin
    nxt_rdata = '0;
    rd_hit    = 1'b1;
    unique case (S_AXI_ARADDR_I)
      asq_pkg::OFF_ACTIVE: nxt_rdata[NSEQ-1:0] = act_ff;
      asq_pkg::OFF_TRIG_SEL: begin
        for (int n = 0; n < NSEQ; n++) begin
          nxt_rdata[n*STEP +: SEL_W] = sel_ff[n*SEL_W +: SEL_W];
        end
      end
      asq_pkg::OFF_PRI_MAP: begin
        for (int n = 0; n < NSEQ; n++) begin
          nxt_rdata[n*STEP +: PRI_W] = pri_ff[n*PRI_W +: PRI_W];
        end
      end
      asq_pkg::OFF_INITIATE: nxt_rdata = '0;
      asq_pkg::OFF_STATUS: begin
        nxt_rdata[asq_pkg::STAT_PEND_LSB +: NSEQ] = pend_ff;
        nxt_rdata[asq_pkg::STAT_RUN_LSB +: NSEQ]  = run_ff;
        nxt_rdata[asq_pkg::STAT_BUSY_BIT]         = (state_ff == asq_pkg::ST_RUN);
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= asq_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID_I && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= rd_hit ? asq_pkg::RESP_OKAY : asq_pkg::RESP_SLVERR;
    end else if (rvalid_ff && S_AXI_RREADY_I) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign S_AXI_AWREADY_O = awready_ff;
  assign S_AXI_WREADY_O  = wready_ff;
  assign S_AXI_BVALID_O  = bvalid_ff;
  assign S_AXI_BRESP_O   = bresp_ff;
  assign S_AXI_ARREADY_O = arready_ff;
  assign S_AXI_RVALID_O  = rvalid_ff;
  assign S_AXI_RDATA_O   = rdata_ff;
  assign S_AXI_RRESP_O   = rresp_ff;
  assign SEQ_TRIG_O      = trig_ff;
  assign SEQ_START_O     = start_ff;
  assign SEQ_RUN_O       = run_ff;
  assign ACTIVE_SEQ_O    = act_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks; helper flags an outranking pending sequencer at a start
  logic better_pending;
  logic [11:0] rd_addr_ff;

  always_comb begin
    better_pending = 1'b0;
    for (int a = 0; a < NSEQ; a++) begin
      for (int b = 0; b < NSEQ; b++) begin
        if (grant[a] && pend_ff[b] && b != a
            && pri_ff[b*PRI_W +: PRI_W] < pri_ff[a*PRI_W +: PRI_W]) begin
          better_pending = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rd_addr_ff <= '0;
    end else if (S_AXI_ARVALID_I && arready_ff) begin
      rd_addr_ff <= S_AXI_ARADDR_I;
    end
  end

  property p_reset_map;
    @(posedge CLOCK_I) $rose(RST_N_I) |-> pri_ff == 8'hE4;
  endproperty
  a_reset_map: assert property (p_reset_map) else $error("priority map not default");

  property p_rank;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (state_ff == asq_pkg::ST_IDLE && grant_valid) |-> !better_pending ##1 start_ff == $past(grant);
  endproperty
  a_rank: assert property (p_rank) else $error("start skipped a higher priority");

  property p_field_pos;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      $rose(rvalid_ff) && rd_addr_ff == asq_pkg::OFF_PRI_MAP |->
        {rdata_ff[13:12], rdata_ff[9:8], rdata_ff[5:4], rdata_ff[1:0]} == $past(pri_ff);
  endproperty
  a_field_pos: assert property (p_field_pos) else $error("priority field misplaced");

  property p_reserved;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      $rose(rvalid_ff) && rd_addr_ff == asq_pkg::OFF_PRI_MAP |->
        (rdata_ff & 32'hFFFF_CCCC) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_active_only;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (trig_ff != '0) |-> (trig_ff & ~$past(act_ff)) == '0;
  endproperty
  a_active_only: assert property (p_active_only) else $error("trigger on inactive");

  property p_order;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (start_ff != '0) |-> $onehot(start_ff) && (start_ff & ~$past(pend_ff)) == '0
        ##1 start_ff == '0;
  endproperty
  a_order: assert property (p_order) else $error("start not from pending");

  property p_wo_read;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      $rose(rvalid_ff) && rd_addr_ff == asq_pkg::OFF_INITIATE |-> rdata_ff == 32'h0000_0000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("initiate read not zero");

  property p_decode;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      wr_do && awaddr_ff == asq_pkg::OFF_PRI_MAP && wstrb_ff[1:0] == 2'b11 |=>
        pri_ff == {$past(wdata_ff[13:12]), $past(wdata_ff[9:8]),
                   $past(wdata_ff[5:4]), $past(wdata_ff[1:0])} && bvalid_ff;
  endproperty
  a_decode: assert property (p_decode) else $error("priority write not decoded");

  property p_source;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      trig_ff[0] |-> $past(sel_ff[3:0]) == asq_pkg::SEL_SOFTWARE;
  endproperty
  a_source: assert property (p_source) else $error("trigger with hardware source");

  property p_pulse;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (trig_ff != '0) |=> trig_ff == '0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger latched");
endmodule

/* pkg/asq_pkg.sv */
// Purpose: shared constants and types for the sequencer priority and trigger block
// Assumes: 32-bit register bus, four sequencers
// Notes:   offsets are byte addresses within the converter register space
package asq_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          NSEQ          = 4;
  localparam int          PRI_W         = 2;
  localparam int          SEL_W         = 4;
  localparam int          FIELD_STEP    = 4;
  localparam int          BYTE_W        = 8;

  localparam logic [11:0] OFF_ACTIVE    = 12'h000;
  localparam logic [11:0] OFF_TRIG_SEL  = 12'h014;
  localparam logic [11:0] OFF_PRI_MAP   = 12'h020;
  localparam logic [11:0] OFF_INITIATE  = 12'h028;
  localparam logic [11:0] OFF_STATUS    = 12'h030;

  localparam logic [31:0] PRI_RESET     = 32'h0000_3210;
  localparam logic [15:0] SEL_RESET     = 16'h0000;
  localparam logic [3:0]  ACTIVE_RESET  = 4'h0;
  localparam logic [3:0]  SEL_SOFTWARE  = 4'h0;

  localparam int          STAT_PEND_LSB = 0;
  localparam int          STAT_RUN_LSB  = 4;
  localparam int          STAT_BUSY_BIT = 8;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } asq_state_t;
endpackage

/* verif/asq_top_tb.sv */
// Purpose: self-checking bench for the sequencer priority and trigger block
// Assumes: AXI4-Lite master driven here, converter done pulses made by the bench
// Notes:   expectations queue up at the driver and a monitor pops them as results show
module asq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic [11:0] awaddr    = 12'h000;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0000_0000;
  logic [3:0]  wstrb     = 4'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [11:0] araddr    = 12'h000;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        seq_done  = 1'b0;
  logic        awready_o;
  logic        wready_o;
  logic [1:0]  bresp_o;
  logic        bvalid_o;
  logic        arready_o;
  logic [31:0] rdata_o;
  logic [1:0]  rresp_o;
  logic        rvalid_o;
  logic [3:0]  seq_trig_o;
  logic [3:0]  seq_start_o;
  logic [3:0]  seq_run_o;
  logic [3:0]  active_o;
  logic [33:0] rd_q[$];
  logic [33:0] wr_q[$];
  logic [33:0] tr_q[$];
  logic [33:0] st_q[$];
  logic [33:0] st_exp;
  int          bad_count = 0;
  int          checks    = 0;
  int          cyc       = 0;

  asq_top i_asq_top (
    .CLOCK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready_o),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready_o), .S_AXI_BRESP_O(bresp_o), .S_AXI_BVALID_O(bvalid_o),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready_o), .S_AXI_RDATA_O(rdata_o), .S_AXI_RRESP_O(rresp_o),
    .S_AXI_RVALID_O(rvalid_o), .S_AXI_RREADY_I(rready), .SEQ_DONE_I(seq_done),
    .SEQ_TRIG_O(seq_trig_o), .SEQ_START_O(seq_start_o), .SEQ_RUN_O(seq_run_o),
    .ACTIVE_SEQ_O(active_o)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // called just after a rising edge; trailing edge keeps valids from being set twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    wr_q.push_back({32'h0000_0000, r});
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready_o) awvalid <= 1'b0;
      if (wvalid && wready_o) wvalid <= 1'b0;
    end while (!(bvalid_o && bready));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rd_q.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready_o) arvalid <= 1'b0;
    end while (!(rvalid_o && rready));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // starts come out lowest code first
  task automatic exp_run(input logic [3:0] t, input logic [31:0] m);
    if (t != 4'h0) tr_q.push_back({30'h0, t});
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < 4; n++) begin
        if (t[n] && m[n*4 +: 2] == c[1:0]) st_q.push_back({30'h0, 4'h1 << n});
      end
    end
  endtask

  task automatic wait_idle();
    while (st_q.size() != 0 || seq_run_o !== 4'h0) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst_n) begin
      if (rvalid_o && rready)
        chk("read", {rresp_o, rdata_o}, rd_q.size() != 0 ? rd_q.pop_front() : 'x);
      if (bvalid_o && bready)
        chk("bresp", {32'h0000_0000, bresp_o}, wr_q.size() != 0 ? wr_q.pop_front() : 'x);
      if (seq_trig_o !== 4'h0)
        chk("trig", {30'h0, seq_trig_o}, tr_q.size() != 0 ? tr_q.pop_front() : 'x);
      if (seq_start_o !== 4'h0) begin
        st_exp = st_q.size() != 0 ? st_q.pop_front() : 'x;
        chk("start", {30'h0, seq_start_o}, st_exp);
        chk("run", {30'h0, seq_run_o}, st_exp);
      end
    end
  end

  // converter stand-in: ends each run after a short random delay
  initial begin
    forever begin
      @(posedge clk);
      if (rst_n && (|seq_run_o) === 1'b1) begin
        repeat ($urandom_range(4)) @(posedge clk);
        seq_done <= 1'b1;
        @(posedge clk);
        seq_done <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] m;
    logic [31:0] d;
    logic [3:0]  act;
    logic [3:0]  t;
    logic [1:0]  p[4];
    logic [1:0]  tmp;
    int          j;
    d = $urandom(32'h3BAF);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(asq_pkg::OFF_PRI_MAP, asq_pkg::PRI_RESET, asq_pkg::RESP_OKAY);
    rd(asq_pkg::OFF_INITIATE, 32'h0000_0000, asq_pkg::RESP_OKAY);
    wr(asq_pkg::OFF_PRI_MAP, 32'hFFFF_FFFF, 4'hF, asq_pkg::RESP_OKAY);
    rd(asq_pkg::OFF_PRI_MAP, 32'h0000_3333, asq_pkg::RESP_OKAY);
    wr(asq_pkg::OFF_PRI_MAP, 32'h0000_0000, 4'h2, asq_pkg::RESP_OKAY);
    rd(asq_pkg::OFF_PRI_MAP, 32'h0000_0033, asq_pkg::RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      // distinct codes only, duplicates would start the lowest index first
      p = '{2'h0, 2'h1, 2'h2, 2'h3};
      for (int n = 3; n > 0; n--) begin
        j = $urandom_range(n);
        tmp = p[n];
        p[n] = p[j];
        p[j] = tmp;
      end
      m = $urandom();
      for (int n = 0; n < 4; n++) m[n*4 +: 2] = p[n];
      wr(asq_pkg::OFF_PRI_MAP, m, 4'hF, asq_pkg::RESP_OKAY);
      rd(asq_pkg::OFF_PRI_MAP, m & 32'h0000_3333, asq_pkg::RESP_OKAY);
      act = (k < 2) ? 4'hF : 4'($urandom_range(15));
      wr(asq_pkg::OFF_ACTIVE, {28'h0, act}, 4'hF, asq_pkg::RESP_OKAY);
      chk("active", {30'h0, active_o}, {30'h0, act});
      t = (k < 2) ? 4'hF : 4'($urandom_range(15));
      d = $urandom();
      d[3:0] = t;
      exp_run(t & act, m);
      wr(asq_pkg::OFF_INITIATE, d, 4'hF, asq_pkg::RESP_OKAY);
      wait_idle();
    end
    wr(asq_pkg::OFF_ACTIVE, 32'h0000_000F, 4'hF, asq_pkg::RESP_OKAY);
    wr(asq_pkg::OFF_TRIG_SEL, 32'h0000_0500, 4'hF, asq_pkg::RESP_OKAY);
    exp_run(4'hB, m);
    wr(asq_pkg::OFF_INITIATE, 32'h0000_000F, 4'hF, asq_pkg::RESP_OKAY);
    wait_idle();
    wr(asq_pkg::OFF_TRIG_SEL, 32'h0000_0000, 4'hF, asq_pkg::RESP_OKAY);
    // zeros and reserved ones must not fire anything
    wr(asq_pkg::OFF_INITIATE, 32'hFFFF_FFF0, 4'hF, asq_pkg::RESP_OKAY);
    repeat (4) @(posedge clk);
    wr(12'h0FC, 32'h0000_0001, 4'hF, asq_pkg::RESP_SLVERR);
    rd(12'h0FC, 32'h0000_0000, asq_pkg::RESP_SLVERR);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(asq_pkg::OFF_PRI_MAP, asq_pkg::PRI_RESET, asq_pkg::RESP_OKAY);
    rd(asq_pkg::OFF_ACTIVE, 32'h0000_0000, asq_pkg::RESP_OKAY);
    wrap_up();
  end
endmodule
